// File: core/dpa_arbiter.sv
`timescale 1ns/100ps
module dpa_arbiter import dpa_pkg::*; #(
    parameter int PROG_CYC = PROG_RST_CYC,
    parameter int INIT_CYC = INIT_HOLD_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // local cpu side
    input wire logic locReq,
    input wire dpa_kind_t locKind,
    input wire logic locWrite,
    input wire logic locAddrZero,
    input wire logic [7:0] locWdata,
    input wire logic locLock,
    output logic cpuReady,
    output logic [7:0] locRdata,
    // system bus slave pins
    input wire logic sysReq,
    input wire logic sysWrite,
    input wire logic sysAddrZero,
    input wire logic [7:0] sysWdata,
    input wire logic sysLock,
    output logic sysAck,
    output logic [7:0] sysRdata,
    // system bus pass-through
    output logic sysBusReq,
    input wire logic sysBusAck,
    // interrupts
    output logic [7:0] picIrq,
    output logic [7:0] sysIntOut,
    output logic [7:0] sysIntOe,
    // reset and initialization
    input wire logic auxRst_n,
    output logic initOut,
    output logic initOe,
    output logic cpuRst,
    output logic portInputMode,
    output logic arbDriveEn,
    output logic modRst,
    // configuration straps
    input wire logic slaveModeEn,
    input wire logic [1:0] romWaits,
    input wire logic [2:0] picRoute,
    input wire logic [2:0] sysIntRoute,
    input wire logic progResetEn,
    input wire logic longResetMode,
    // status
    output dpa_arb_t arbState
);
    localparam int PW = 14;
    localparam int SYS_LAT = SYS_GRANT_CYC;
    localparam int DIV_LAT = CPU_DIV_CYC + 1;
    localparam int PCW = $clog2(PROG_CYC + 1);
    localparam int ICW = $clog2(INIT_CYC + 1);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PW-1:0] pinRaw;
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] pinF;
    logic sysReqF;
    logic sysWriteF;
    logic sysAddrZeroF;
    logic sysLockF;
    logic sysBusAckF;
    logic auxF;
    logic [7:0] sysWdataF;

    assign pinRaw = {~auxRst_n, sysBusAck, sysLock, sysWrite, sysAddrZero, sysReq, sysWdata};
    assign sysWdataF = pinF[7:0];
    assign sysReqF = pinF[8];
    assign sysAddrZeroF = pinF[9];
    assign sysWriteF = pinF[10];
    assign sysLockF = pinF[11];
    assign sysBusAckF = pinF[12];
    assign auxF = pinF[13];

    for (genvar i = 0; i < PW; i++) begin : g_sync
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                s1[i] <= 1'b0;
                s2[i] <= 1'b0;
                s3[i] <= 1'b0;
                pinF[i] <= 1'b0;
            end else begin
                s1[i] <= pinRaw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    pinF[i] <= s3[i];
                end
            end
        end
    end

    // ----------------------------------------
    // cpu clock enable
    // ----------------------------------------
    logic [4:0] cpuDiv;
    logic cpuTick;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpuDiv <= 5'h00;
            cpuTick <= 1'b0;
        end else begin
            cpuTick <= (cpuDiv == 5'(CPU_DIV_CYC - 1));
            cpuDiv <= (cpuDiv == 5'(CPU_DIV_CYC - 1)) ? 5'h00 : cpuDiv + 5'h01;
        end
    end

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    logic reqSeen;
    logic passing;
    logic [4:0] passCnt;
    logic localStart;
    logic dpStart;
    logic sysAccept;
    logic passDone;
    logic waitDone;
    logic waitBusy;
    logic [1:0] waitCount;
    logic locWr0;
    logic sysWr0;
    logic [7:0] wrData;
    logic initActive;
    logic progRst;

    always_comb begin
        localStart = locReq && !reqSeen && !cpuRst;
        // dual port use only from idle or own ownership
        dpStart = localStart && locKind == KIND_DPRAM && arbState != ARB_SYS;
        if (locKind == KIND_DPRAM) begin
            localStart = dpStart;
        end
        // local wins a tie in idle
        sysAccept = sysReqF && !sysAck && (arbState == ARB_SYS || (arbState == ARB_IDLE && !dpStart));
        waitCount = (locKind == KIND_ROM) ? romWaits : DP_WAITS;
        passDone = passing && sysBusAckF && passCnt >= 5'(PASS_MIN_CYC - 1);
        locWr0 = dpStart && locWrite && locAddrZero;
        sysWr0 = sysAccept && sysWriteF && sysAddrZeroF;
        wrData = locWr0 ? locWdata : sysWdataF;
    end

    dpa_wait_gen u_wait (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cpuTick(cpuTick),
        .start(localStart && locKind != KIND_SYSBUS),
        .waits(waitCount),
        .done(waitDone),
        .busy(waitBusy)
    );

    // ----------------------------------------
    // local cycle tracking
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqSeen <= 1'b0;
            cpuReady <= 1'b0;
        end else begin
            if (!locReq) begin
                reqSeen <= 1'b0;
            end else if (localStart) begin
                reqSeen <= 1'b1;
            end
            cpuReady <= waitDone || passDone;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            passing <= 1'b0;
            passCnt <= 5'h00;
            sysBusReq <= 1'b0;
        end else begin
            if (localStart && locKind == KIND_SYSBUS) begin
                passing <= 1'b1;
                sysBusReq <= 1'b1;
                passCnt <= 5'h00;
            end else if (passDone || cpuRst) begin
                passing <= 1'b0;
                sysBusReq <= 1'b0;
            end else if (passing && passCnt != 5'h1F) begin
                passCnt <= passCnt + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // ownership state machine
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arbState <= ARB_IDLE;
        end else begin
            case (arbState)
                ARB_IDLE: begin
                    if (dpStart) begin
                        arbState <= ARB_LOC;
                    end else if (sysAccept) begin
                        arbState <= ARB_SYS;
                    end
                end
                ARB_LOC: begin
                    if (!locLock && !(locReq && locKind == KIND_DPRAM) && !waitBusy) begin
                        arbState <= ARB_IDLE;
                    end
                end
                ARB_SYS: begin
                    if (!sysReqF && !sysLockF) begin
                        arbState <= ARB_IDLE;
                    end
                end
                default: begin
                    arbState <= ARB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysAck <= 1'b0;
        end else if (sysAccept) begin
            sysAck <= 1'b1;
        end else if (!sysReqF) begin
            sysAck <= 1'b0;
        end
    end

    // ----------------------------------------
    // mailbox word
    // ----------------------------------------
    logic [7:0] mailbox;
    logic picIrqFlag;
    logic sysIrqFlag;

    // reads return the word, flags untouched
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mailbox <= MBX_RESET;
            locRdata <= 8'h00;
            sysRdata <= 8'h00;
        end else begin
            if (locWr0 || sysWr0) begin
                mailbox <= wrData;
            end
            if (dpStart && !locWrite && locAddrZero) begin
                locRdata <= mailbox;
            end
            if (sysAccept && !sysWriteF && sysAddrZeroF) begin
                sysRdata <= mailbox;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            picIrqFlag <= 1'b0;
        end else if (initActive) begin
            picIrqFlag <= 1'b0;
        end else if (sysWr0 && wrData == MBX_IRQ && slaveModeEn) begin
            picIrqFlag <= 1'b1;
        end else if (locWr0 && wrData == MBX_CLR) begin
            picIrqFlag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysIrqFlag <= 1'b0;
        end else if (initActive) begin
            sysIrqFlag <= 1'b0;
        end else if (locWr0 && wrData == MBX_IRQ) begin
            sysIrqFlag <= 1'b1;
        end else if (sysWr0 && wrData == MBX_CLR) begin
            sysIrqFlag <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt routing
    // ----------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_route
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                picIrq[i] <= 1'b0;
                sysIntOe[i] <= 1'b0;
                sysIntOut[i] <= 1'b0;
            end else begin
                picIrq[i] <= picIrqFlag && picRoute == 3'(i);
                sysIntOe[i] <= sysIrqFlag && sysIntRoute == 3'(i);
                sysIntOut[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // program controlled reset
    // ----------------------------------------
    logic [PCW-1:0] progCnt;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            progRst <= 1'b0;
            progCnt <= '0;
        end else if (initActive) begin
            progRst <= 1'b0;
            progCnt <= '0;
        end else if ((locWr0 || sysWr0) && wrData == MBX_RST && progResetEn) begin
            progRst <= 1'b1;
            progCnt <= PCW'(PROG_CYC - 1);
        // long mode waits for system clear
        end else if (progRst && longResetMode) begin
            if (sysWr0 && wrData == MBX_CLR) begin
                progRst <= 1'b0;
            end
        end else if (progRst) begin
            if (progCnt == '0) begin
                progRst <= 1'b0;
            end else begin
                progCnt <= progCnt - PCW'(1);
            end
        end
    end

    // ----------------------------------------
    // initialization
    // ----------------------------------------
    logic [ICW-1:0] initCnt;
    logic nextBoardRst;

    assign initActive = initCnt != '0;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            initCnt <= ICW'(INIT_CYC);
        end else if (auxF) begin
            initCnt <= ICW'(INIT_CYC);
        end else if (initActive) begin
            initCnt <= initCnt - ICW'(1);
        end
    end

    assign nextBoardRst = initActive || progRst;

    // cpu to reset vector, ports in, arbiter off
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            initOe <= 1'b1;
            initOut <= 1'b0;
            cpuRst <= 1'b1;
            modRst <= 1'b1;
            portInputMode <= 1'b1;
            arbDriveEn <= 1'b0;
        end else begin
            initOe <= initActive;
            initOut <= 1'b0;
            cpuRst <= nextBoardRst;
            modRst <= nextBoardRst;
            portInputMode <= nextBoardRst;
            arbDriveEn <= !nextBoardRst;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_waitOne;
        !cpuReady ##[0:DIV_LAT] cpuReady;
    endsequence

    a_local_grant: assert property (dpStart && arbState == ARB_IDLE |=> arbState == ARB_LOC)
        else $error("local request not granted");
    a_sys_grant_time: assert property ($rose(sysReqF) && arbState == ARB_IDLE && !locReq && !reqSeen
        |-> ##[1:SYS_LAT] arbState == ARB_SYS)
        else $error("system grant too slow");
    a_pass_stays_idle: assert property (localStart && locKind == KIND_SYSBUS && arbState == ARB_IDLE
        && !sysAccept |=> arbState == ARB_IDLE)
        else $error("pass-through took ownership");
    a_pass_overhead: assert property ($rose(sysBusReq) |-> !cpuReady [*8])
        else $error("pass-through overhead too short");
    a_dp_one_wait: assert property (dpStart |=> s_waitOne)
        else $error("dual port wait state wrong");
    a_pic_irq_set: assert property (sysWr0 && wrData == MBX_IRQ && slaveModeEn && !initActive
        |=> ##1 picIrq != 8'h00)
        else $error("local interrupt not raised");
    a_pic_irq_clear: assert property (locWr0 && wrData == MBX_CLR |=> ##1 picIrq == 8'h00)
        else $error("local interrupt not withdrawn");
    a_sys_irq_set: assert property (locWr0 && wrData == MBX_IRQ && !initActive
        |=> ##1 sysIntOe != 8'h00)
        else $error("system interrupt not raised");
    a_prog_rst_en: assert property ($rose(progRst) |-> $past(progResetEn))
        else $error("program reset while disabled");
    a_prog_rst_pulse: assert property ($rose(progRst) && !longResetMode |-> progRst [*8])
        else $error("program reset pulse too short");
    a_board_only: assert property (progRst && !initActive |=> !initOe && cpuRst)
        else $error("program reset reached init line");
    a_lock_local: assert property (arbState == ARB_LOC && locLock |=> arbState == ARB_LOC)
        else $error("locked local ownership lost");
    a_tie_local: assert property (arbState == ARB_IDLE && dpStart && sysReqF && !sysAck
        |=> arbState == ARB_LOC && !sysAck)
        else $error("tie not granted to local side");
endmodule

// File: core/dpa_pkg.sv
// Behaviour
// - dual port bus has idle, local-busy, system-busy states; idle belongs to local side.
// - local dual port request moves idle to local-busy, waiting if busy; back on completion.
// - system request reaches system-busy within 150 ns, waiting if busy; back on completion.
// - local accesses to system bus pass through, leaving idle, with 200 ns least overhead.
// - every on-board access except read-only memory gets exactly one CPU wait state.
// - read-only memory accesses get a configured count of zero, one or two wait states.
// - in slave mode a system write of 01H to word zero raises the local interrupt.
// - a local write of 00H to word zero withdraws the local interrupt.
// - word zero reads like RAM from both ports and leaves both interrupts alone.
// - a local write of 01H to word zero raises a system interrupt line.
// - the local mailbox interrupt routes to any of eight controller inputs.
// - a 02H write to word zero makes a board reset pulse of 2 to 4 ms.
// - a configuration bit enables the program reset; when off, 02H does nothing.
// - in long mode the program reset holds until a system write of 00H.
// - program reset resets this board only, never the system initialization line.
// - at power-up drive the system initialization line and derive board reset from it.
// - board reset holds CPU, ports as inputs, arbiter outputs off, add-on modules reset.
// - the auxiliary reset input at any time repeats the full power-up initialization.
// - locked local exchange keeps local ownership; system lock keeps system ownership.
package dpa_pkg;
    // ----------------------------------------
    // clocking and timing
    // ----------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int CPU_HZ = 4_800_000;
    localparam int CPU_DIV_CYC = CLK_HZ / CPU_HZ;
    localparam int SYS_GRANT_NS = 150;
    localparam int SYS_GRANT_CYC = (SYS_GRANT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int PASS_MIN_NS = 200;
    localparam int PASS_MIN_CYC = (PASS_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PROG_RST_MS = 2;
    localparam int PROG_RST_CYC = PROG_RST_MS * (CLK_HZ / 1000);
    localparam int INIT_HOLD_CYC = 16;
    localparam int SYNC_STAGES = 3;
    // ----------------------------------------
    // mailbox and reset values
    // ----------------------------------------
    localparam logic [9:0] MBX_OFFSET = 10'h000;
    localparam logic [7:0] MBX_RESET = 8'h00;
    localparam logic [7:0] MBX_CLR = 8'h00;
    localparam logic [7:0] MBX_IRQ = 8'h01;
    localparam logic [7:0] MBX_RST = 8'h02;
    localparam logic [1:0] DP_WAITS = 2'h1;
    localparam logic [19:0] RESET_VECTOR = 20'hFFFF0;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {ARB_IDLE, ARB_LOC, ARB_SYS} dpa_arb_t;
    typedef enum logic [1:0] {KIND_DPRAM, KIND_ROM, KIND_ONBOARD, KIND_SYSBUS} dpa_kind_t;
endpackage

// File: core/dpa_wait_gen.sv
`timescale 1ns/100ps
module dpa_wait_gen import dpa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // cpu clock enable
    input wire logic cpuTick,
    // request
    input wire logic start,
    input wire logic [1:0] waits,
    // answer
    output logic done,
    output logic busy
);
    logic [1:0] left;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            left <= 2'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                if (waits == 2'h0) begin
                    done <= 1'b1;
                end else begin
                    busy <= 1'b1;
                    left <= waits;
                end
            end else if (busy && cpuTick) begin
                left <= left - 2'h1;
                if (left == 2'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// File: verification/dpa_far_side.sv
`timescale 1ns/100ps
module dpa_far_side import dpa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bench commands
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] wd,
    input wire logic lk,
    output logic done,
    // system bus slave pins
    output logic sysReq,
    output logic sysWrite,
    output logic sysAddrZero,
    output logic [7:0] sysWdata,
    output logic sysLock,
    input wire logic sysAck,
    // pass-through answer
    input wire logic sysBusReq,
    output logic sysBusAck
);
    logic [3:0] dly;
    // ----------------------------------------
    // system master
    // ----------------------------------------
    // request held to ack, lock per command
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysReq <= 1'b0;
            sysWrite <= 1'b0;
            sysAddrZero <= 1'b0;
            sysWdata <= 8'h00;
            sysLock <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            sysLock <= lk;
            if (!sysReq && !sysAck && go && !done) begin
                sysReq <= 1'b1;
                sysWrite <= wr;
                sysAddrZero <= 1'b1;
                sysWdata <= wd;
            end else if (sysReq && sysAck) begin
                // released lines no longer show the last value
                sysReq <= 1'b0;
                sysWrite <= ~sysWrite;
                sysAddrZero <= ~sysAddrZero;
                sysWdata <= ~sysWdata;
                done <= 1'b1;
            end
        end
    end
    // ----------------------------------------
    // pass-through target
    // ----------------------------------------
    // slow answer to a local exchange
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst || !sysBusReq) begin
            dly <= 4'h0;
            sysBusAck <= 1'b0;
        end else if (dly != 4'hF) begin
            dly <= dly + 4'h1;
        end else begin
            sysBusAck <= 1'b1;
        end
    end
endmodule

// File: verification/dual_port_arbiter_mailbox_tb_top.sv
`timescale 1ns/100ps
module dual_port_arbiter_mailbox_tb_top import dpa_pkg::*;;
    logic ref_clk, sys_rst, locReq, locWrite, locAddrZero, locLock, auxRst_n, slaveModeEn, progResetEn;
    logic longResetMode, go, wr, lk, done, cpuReady, sysReq, sysWrite, sysAddrZero, sysLock, sysAck;
    logic sysBusReq, sysBusAck, initOut, initOe, cpuRst, portInputMode, arbDriveEn, modRst;
    logic [7:0] locWdata, wd, locRdata, sysWdata, sysRdata, picIrq, sysIntOut, sysIntOe;
    logic [1:0] romWaits;
    logic [2:0] picRoute, sysIntRoute;
    dpa_kind_t locKind;
    dpa_arb_t arbState;
    logic sawBusy = 1'b0;
    int badCount, numChecks, n, r0, i0, rstLen, initSeen, readyCount;

    dpa_arbiter #(.PROG_CYC(40), .INIT_CYC(4)) dpa_arbiter_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .locReq(locReq), .locKind(locKind), .locWrite(locWrite), .locAddrZero(locAddrZero),
        .locWdata(locWdata), .locLock(locLock), .cpuReady(cpuReady), .locRdata(locRdata), .sysReq(sysReq),
        .sysWrite(sysWrite), .sysAddrZero(sysAddrZero), .sysWdata(sysWdata), .sysLock(sysLock),
        .sysAck(sysAck), .sysRdata(sysRdata), .sysBusReq(sysBusReq), .sysBusAck(sysBusAck), .picIrq(picIrq),
        .sysIntOut(sysIntOut), .sysIntOe(sysIntOe), .auxRst_n(auxRst_n), .initOut(initOut), .initOe(initOe),
        .cpuRst(cpuRst), .portInputMode(portInputMode), .arbDriveEn(arbDriveEn), .modRst(modRst),
        .slaveModeEn(slaveModeEn), .romWaits(romWaits), .picRoute(picRoute), .sysIntRoute(sysIntRoute),
        .progResetEn(progResetEn), .longResetMode(longResetMode), .arbState(arbState));
    dpa_far_side dpa_far_side_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .wr(wr), .wd(wd),
        .lk(lk), .done(done), .sysReq(sysReq), .sysWrite(sysWrite), .sysAddrZero(sysAddrZero),
        .sysWdata(sysWdata), .sysLock(sysLock), .sysAck(sysAck), .sysBusReq(sysBusReq), .sysBusAck(sysBusAck));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (cpuRst === 1'b1) rstLen++;
        if (initOe === 1'b1) initSeen++;
        if (cpuReady === 1'b1) readyCount++;
        if (sysBusReq === 1'b1 && arbState !== ARB_IDLE) sawBusy = 1'b1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stopTest;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic locAcc(input dpa_kind_t k, input logic w, input logic [7:0] d, output int c);
        locReq <= 1'b1;
        locKind <= k;
        locWrite <= w;
        locAddrZero <= 1'b1;
        locWdata <= d;
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (cpuReady !== 1'b1 && c < 400);
        if (c >= 400) begin
            chk(0, 1);
            stopTest;
        end
        locReq <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic sysAcc(input logic w, input logic [7:0] d, input logic l, output int c);
        go <= 1'b1;
        wr <= w;
        wd <= d;
        lk <= l;
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (done !== 1'b1 && c < 400);
        if (c >= 400) begin
            chk(0, 1);
            stopTest;
        end
        go <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic waitRst;
        int k;
        for (k = 0; k < 200 && cpuRst !== 1'b0; k++) @(posedge ref_clk);
        if (cpuRst !== 1'b0) begin
            chk(0, 1);
            stopTest;
        end
        @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {sys_rst, locReq, locWrite, locAddrZero, locLock, go, wr, lk, romWaits} = 10'h200;
        {auxRst_n, slaveModeEn, progResetEn, longResetMode} = 4'hE;
        {locWdata, wd, picRoute, sysIntRoute} = 22'h00002A;
        locKind = KIND_DPRAM;
        repeat (20) @(posedge ref_clk);
        chk({initOe, initOut, cpuRst, modRst, portInputMode, arbDriveEn}, 6'h2E);
        chk(arbState, ARB_IDLE);
        sys_rst <= 1'b0;
        waitRst;
        chk({initOe, arbDriveEn, portInputMode, modRst}, 4'h4);
        sysAcc(1'b1, 8'h01, 1'b0, n);
        chk(n <= 20, 1);
        chk(picIrq, 8'h20);
        locAcc(KIND_DPRAM, 1'b0, 8'h00, n);
        chk({locRdata, picIrq}, 16'h0120);
        locAcc(KIND_DPRAM, 1'b1, 8'h00, n);
        chk(picIrq, 8'h00);
        chk(arbState, ARB_IDLE);
        locAcc(KIND_DPRAM, 1'b1, 8'h01, n);
        chk({sysIntOe, sysIntOut}, 16'h0400);
        sysAcc(1'b0, 8'h00, 1'b0, n);
        chk({sysRdata, sysIntOe}, 16'h0104);
        sysAcc(1'b1, 8'h00, 1'b0, n);
        chk(sysIntOe, 8'h00);
        // locked local exchange blocks the system side
        locLock <= 1'b1;
        locAcc(KIND_DPRAM, 1'b0, 8'h00, n);
        go <= 1'b1;
        repeat (30) @(posedge ref_clk);
        chk({sysAck, arbState}, 3'h1);
        locLock <= 1'b0;
        sysAcc(1'b1, 8'h00, 1'b0, n);
        chk(arbState, ARB_IDLE);
        locAcc(KIND_ONBOARD, 1'b0, 8'h00, n);
        chk(n >= 4 && n <= 30, 1);
        for (int w = 0; w < 3; w++) begin
            romWaits <= 2'(w);
            @(posedge ref_clk);
            locAcc(KIND_ROM, 1'b0, 8'h00, n);
            chk(n >= (w == 0 ? 3 : w * 26 - 24) && n <= (w == 0 ? 5 : w * 26 + 6), 1);
        end
        locAcc(KIND_SYSBUS, 1'b1, 8'h55, n);
        chk({n >= 27, sawBusy, sysBusReq}, 3'h4);
        sysAcc(1'b0, 8'h00, 1'b1, n);
        r0 = readyCount;
        locReq <= 1'b1;
        locKind <= KIND_DPRAM;
        repeat (40) @(posedge ref_clk);
        chk({readyCount - r0, arbState}, ARB_SYS);
        lk <= 1'b0;
        locAcc(KIND_DPRAM, 1'b0, 8'h00, n);
        chk(n <= 60, 1);
        {r0, i0} = {rstLen, initSeen};
        sysAcc(1'b1, 8'h02, 1'b0, n);
        waitRst;
        chk(rstLen - r0 >= 40 && rstLen - r0 <= 42, 1);
        chk(initSeen - i0, 0);
        longResetMode <= 1'b1;
        sysAcc(1'b1, 8'h02, 1'b0, n);
        repeat (100) @(posedge ref_clk);
        chk(cpuRst, 1);
        sysAcc(1'b1, 8'h00, 1'b0, n);
        waitRst;
        {progResetEn, longResetMode} <= 2'h0;
        r0 = rstLen;
        sysAcc(1'b1, 8'h02, 1'b0, n);
        repeat (60) @(posedge ref_clk);
        chk(rstLen - r0, 0);
        i0 = initSeen;
        auxRst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        auxRst_n <= 1'b1;
        waitRst;
        chk(initSeen - i0 > 4, 1);
        stopTest;
    end
endmodule
